//--- hw/dds_dual.sv
`timescale 1ns/1ns
`default_nettype none
module dds_dual
  import dds_pkg::*;
#(
  parameter int FIFO_DEPTH = FIFO_DEPTH_DEF
) (
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rst,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  // Sample stream to converters
  output logic             out_valid,
  input  wire logic        out_ready,
  output logic [15:0]      first_output_port,
  output logic [15:0]      second_output_port
);
  // Bus data phase
  logic              ph_wr;
  logic [7:0]        ph_addr;
  // Channel parameters
  logic [IDEAL_W-1:0] a_ideal;
  logic [IDEAL_W-1:0] b_ideal;
  logic [IDEAL_W-1:0] next_a_ideal;
  logic [IDEAL_W-1:0] next_b_ideal;
  logic [15:0]        a_amp;
  logic [15:0]        b_amp;
  logic [15:0]        next_a_amp;
  logic [15:0]        next_b_amp;
  logic [15:0]        a_phase;
  logic [15:0]        b_phase;
  logic [15:0]        next_a_phase;
  logic [15:0]        next_b_phase;
  logic [2:0]         a_wave;
  logic [2:0]         b_wave;
  logic [2:0]         next_a_wave;
  logic [2:0]         next_b_wave;
  logic               commit_a;
  logic               commit_b;
  // Control and coupling
  logic [CTRL_W-1:0]  ctrl;
  logic [CTRL_W-1:0]  next_ctrl;
  logic [15:0]        cpl_f_k;
  logic [15:0]        cpl_a_k;
  logic [15:0]        cpl_p_k;
  // Tuning word calculator
  dds_calc_t          state;
  logic [WORD_W-1:0]  word_a;
  logic [WORD_W-1:0]  word_b;
  logic               dirty_a;
  logic               dirty_b;
  logic [IDEAL_W-1:0] dvd;
  logic [IDEAL_W-1:0] dvs;
  logic [IDEAL_W-1:0] quo;
  logic [IDEAL_W:0]   rem;
  logic [6:0]         cnt;
  logic               hi_is_a;
  logic               harm_hit;
  logic [103:0]       harm_prod;
  // Sample path
  logic [SAMP_W-1:0]  samp_a;
  logic [SAMP_W-1:0]  samp_b;
  logic               samp_valid;
  logic               fifo_ready;

  function automatic logic [WORD_W-1:0] rnd(input logic [IDEAL_W-1:0] v);
    return v[IDEAL_W-1:FRAC_W] + {{(WORD_W-1){1'b0}}, v[FRAC_W-1]};
  endfunction : rnd

  function automatic logic [IDEAL_W-1:0] cpl_f(input logic [IDEAL_W-1:0] v,
                                               input logic rat, input logic [15:0] k);
    logic [IDEAL_W+15:0] p;
    p = (IDEAL_W+16)'(v) * (IDEAL_W+16)'(k);
    return rat ? p[IDEAL_W+7:8] : v + {{(IDEAL_W-32){k[15]}}, k, 16'h0000};
  endfunction : cpl_f

  function automatic logic [15:0] cpl16(input logic [15:0] v, input logic rat,
                                        input logic [15:0] k);
    logic [31:0] p;
    p = 32'(v) * 32'(k);
    return rat ? p[23:8] : v + k;
  endfunction : cpl16

  function automatic logic [31:0] chan_rd(input logic [4:0] s,
                                          input logic [IDEAL_W-1:0] id,
                                          input logic [15:0] am, input logic [15:0] ph,
                                          input logic [2:0] wv, input logic [WORD_W-1:0] w);
    case (s)
      REG_FRAC:    return {16'h0000, id[15:0]};
      REG_LO:      return id[47:16];
      REG_HI:      return {12'h000, id[67:48]};
      REG_AMP:     return {16'h0000, am};
      REG_PHASE:   return {16'h0000, ph};
      REG_WAVE:    return {29'h0, wv};
      REG_WORD_LO: return w[31:0];
      REG_WORD_HI: return {12'h000, w[51:32]};
      default:     return 32'h0;
    endcase
  endfunction : chan_rd

  // Bus address phase and read data
  wire        take  = hsel & htrans[1] & hready;
  wire [7:0]  ra    = haddr[7:0];
  wire        rd_a  = (ra[7:5] == OFS_CHAN_A[7:5]);
  wire        rd_b  = (ra[7:5] == OFS_CHAN_B[7:5]);
  wire        busy  = (state != ST_IDLE);
  wire [31:0] stat  = {28'h0, harm_hit, busy, ctrl[CTL_TRACK], ctrl[CTL_LOCK]};
  wire [31:0] rd_word =
    rd_a ? chan_rd(ra[4:0], a_ideal, a_amp, a_phase, a_wave, word_a) :
    rd_b ? chan_rd(ra[4:0], b_ideal, b_amp, b_phase, b_wave, word_b) :
    (ra == OFS_CTRL)      ? {22'h0, ctrl} :
    (ra == OFS_CPL_FREQ)  ? {16'h0000, cpl_f_k} :
    (ra == OFS_CPL_AMP)   ? {16'h0000, cpl_a_k} :
    (ra == OFS_CPL_PHASE) ? {16'h0000, cpl_p_k} :
    (ra == OFS_STATUS)    ? stat : 32'h0;

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ph_wr   <= 1'b0;
      ph_addr <= '0;
      hrdata  <= '0;
    end else begin
      ph_wr <= take & hwrite;
      if (take) begin
        ph_addr <= ra;
      end
      if (take && !hwrite) begin
        hrdata <= rd_word;
      end
    end
  end

  // Write decode in data phase
  wire [4:0] wsub    = ph_addr[4:0];
  wire       track   = ctrl[CTL_TRACK];
  wire       locked  = ctrl[CTL_LOCK];
  wire       wa      = ph_wr & (ph_addr[7:5] == OFS_CHAN_A[7:5]);
  wire       wb      = ph_wr & (ph_addr[7:5] == OFS_CHAN_B[7:5]) & ~track;
  wire       cmd_wr  = ph_wr & (ph_addr == OFS_CMD);
  wire       eq_cmd  = cmd_wr & hwdata[CMD_EQ];
  wire       copy_ab = cmd_wr & hwdata[CMD_CP_AB];
  wire       copy_ba = cmd_wr & hwdata[CMD_CP_BA];
  wire       ph_time = (wa | wb) & (wsub == REG_PHASE);

  // Channel A parameters
  always_comb begin
    next_a_ideal = a_ideal;
    next_a_amp   = a_amp;
    next_a_phase = a_phase;
    next_a_wave  = a_wave;
    commit_a     = 1'b0;
    if (copy_ba) begin
      next_a_ideal = b_ideal;
      next_a_amp   = b_amp;
      next_a_phase = b_phase;
      next_a_wave  = b_wave;
      commit_a     = 1'b1;
    end else if (wa) begin
      case (wsub)
        REG_FRAC:  next_a_ideal[15:0] = hwdata[15:0];
        REG_LO:    next_a_ideal[47:16] = hwdata;
        REG_HI: begin
          next_a_ideal[67:48] = hwdata[19:0];
          commit_a = 1'b1;
        end
        REG_AMP:   next_a_amp = hwdata[15:0];
        REG_PHASE: next_a_phase = hwdata[15:0];
        REG_WAVE:  next_a_wave = hwdata[2:0];
        default:   next_a_wave = a_wave;
      endcase
    end
  end

  // Channel B parameters
  always_comb begin
    next_b_ideal = b_ideal;
    next_b_amp   = b_amp;
    next_b_phase = b_phase;
    next_b_wave  = b_wave;
    commit_b     = 1'b0;
    if (copy_ab) begin
      next_b_ideal = a_ideal;
      next_b_amp   = a_amp;
      next_b_phase = a_phase;
      next_b_wave  = a_wave;
      commit_b     = 1'b1;
    end else if (track) begin
      if (wa) begin
        next_b_ideal = next_a_ideal;
        next_b_amp   = next_a_amp;
        next_b_phase = next_a_phase;
        next_b_wave  = next_a_wave;
        commit_b     = commit_a;
      end
    end else begin
      if (wa && wsub == REG_HI && ctrl[CTL_CPF]) begin
        next_b_ideal = cpl_f(next_a_ideal, ctrl[CTL_RF], cpl_f_k);
        commit_b     = 1'b1;
      end
      if (wa && wsub == REG_AMP && ctrl[CTL_CPA]) begin
        next_b_amp = cpl16(next_a_amp, ctrl[CTL_RA], cpl_a_k);
      end
      if (wa && wsub == REG_PHASE && ctrl[CTL_CPP]) begin
        next_b_phase = cpl16(next_a_phase, ctrl[CTL_RP], cpl_p_k);
      end
      if (wb) begin
        case (wsub)
          REG_FRAC:  next_b_ideal[15:0] = hwdata[15:0];
          REG_LO:    next_b_ideal[47:16] = hwdata;
          REG_HI: begin
            next_b_ideal[67:48] = hwdata[19:0];
            commit_b = 1'b1;
          end
          REG_AMP:   next_b_amp = hwdata[15:0];
          REG_PHASE: next_b_phase = hwdata[15:0];
          REG_WAVE:  next_b_wave = hwdata[2:0];
          default:   next_b_wave = b_wave;
        endcase
      end
    end
  end

  // Control word: tracking forces locked
  always_comb begin
    next_ctrl = hwdata[CTRL_W-1:0];
    next_ctrl[CTL_LOCK] = hwdata[CTL_LOCK] | hwdata[CTL_TRACK];
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      a_ideal <= '0;
      b_ideal <= '0;
      a_amp   <= AMP_RST;
      b_amp   <= AMP_RST;
      a_phase <= '0;
      b_phase <= '0;
      a_wave  <= WAVE_SAW;
      b_wave  <= WAVE_SAW;
    end else begin
      a_ideal <= next_a_ideal;
      b_ideal <= next_b_ideal;
      a_amp   <= next_a_amp;
      b_amp   <= next_b_amp;
      a_phase <= next_a_phase;
      b_phase <= next_b_phase;
      a_wave  <= next_a_wave;
      b_wave  <= next_b_wave;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ctrl    <= '0;
      cpl_f_k <= CPL_RST;
      cpl_a_k <= CPL_RST;
      cpl_p_k <= CPL_RST;
    end else if (ph_wr) begin
      if (ph_addr == OFS_CTRL) ctrl <= next_ctrl;
      if (ph_addr == OFS_CPL_FREQ) cpl_f_k <= hwdata[15:0];
      if (ph_addr == OFS_CPL_AMP) cpl_a_k <= hwdata[15:0];
      if (ph_addr == OFS_CPL_PHASE) cpl_p_k <= hwdata[15:0];
    end
  end

  // Tuning word calculator
  wire               pend     = dirty_a | dirty_b;
  wire               consume  = (state == ST_IDLE) & pend;
  wire               a_ge     = (a_ideal >= b_ideal);
  wire [IDEAL_W:0]   rem_sh   = {rem[IDEAL_W-1:0], dvd[IDEAL_W-1]};
  wire               rem_ge   = (rem_sh >= {1'b0, dvs});
  wire               harmonic = (rem == '0) && (dvs != '0);
  wire [WORD_W-1:0]  lo_word  = rnd(dvs);
  wire [WORD_W-1:0]  hi_round = rnd(hi_is_a ? a_ideal : b_ideal);
  assign harm_prod = quo[WORD_W-1:0] * lo_word;
  wire [WORD_W-1:0]  hi_word  = harmonic ? harm_prod[WORD_W-1:0] : hi_round;
  wire               clr_both = (state == ST_APPLY) | eq_cmd | (locked & ph_time);

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      dirty_a <= 1'b0;
      dirty_b <= 1'b0;
    end else begin
      dirty_a <= (dirty_a & ~consume) | commit_a;
      dirty_b <= (dirty_b & ~consume) | commit_b;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state   <= ST_IDLE;
      dvd     <= '0;
      dvs     <= '0;
      quo     <= '0;
      rem     <= '0;
      cnt     <= '0;
      hi_is_a <= 1'b0;
    end else begin
      case (state)
        ST_IDLE: begin
          if (pend && locked) begin
            dvd     <= a_ge ? a_ideal : b_ideal;
            dvs     <= a_ge ? b_ideal : a_ideal;
            hi_is_a <= a_ge;
            quo     <= '0;
            rem     <= '0;
            cnt     <= DIV_STEPS;
            state   <= ST_DIV;
          end
        end
        ST_DIV: begin
          rem   <= rem_ge ? rem_sh - {1'b0, dvs} : rem_sh;
          quo   <= {quo[IDEAL_W-2:0], rem_ge};
          dvd   <= {dvd[IDEAL_W-2:0], 1'b0};
          cnt   <= cnt - 7'h01;
          if (cnt == 7'h01) begin
            state <= ST_APPLY;
          end
        end
        ST_APPLY: state <= ST_IDLE;
        default:  state <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      word_a   <= '0;
      word_b   <= '0;
      harm_hit <= 1'b0;
    end else if (consume && !locked) begin
      if (dirty_a) word_a <= rnd(a_ideal);
      if (dirty_b) word_b <= rnd(b_ideal);
    end else if (state == ST_APPLY) begin
      word_a   <= hi_is_a ? hi_word : lo_word;
      word_b   <= hi_is_a ? lo_word : hi_word;
      harm_hit <= harmonic;
    end
  end

  // Channel synthesis; accumulators restart together
  dds_chan #(
    .AW (WORD_W)
  ) u_chan_a (
    .sys_clk   (sys_clk),
    .rst       (rst),
    .advance   (fifo_ready),
    .clear     (clr_both),
    .word      (word_a),
    .phase_ofs (a_phase),
    .amp       (a_amp),
    .wave      (a_wave),
    .sample    (samp_a)
  );

  dds_chan #(
    .AW (WORD_W)
  ) u_chan_b (
    .sys_clk   (sys_clk),
    .rst       (rst),
    .advance   (fifo_ready),
    .clear     (clr_both),
    .word      (word_b),
    .phase_ofs (b_phase),
    .amp       (b_amp),
    .wave      (b_wave),
    .sample    (samp_b)
  );

  // Port selection and saturating sum of any waveform pair
  wire signed [16:0] sum_raw = $signed({samp_a[15], samp_a}) + $signed({samp_b[15], samp_b});
  wire        sum_ovf = (sum_raw[16] != sum_raw[15]);
  wire [15:0] sum_sat = sum_ovf ? (sum_raw[16] ? SAT_NEG : SAT_POS) : sum_raw[15:0];
  wire [15:0] port1_w = ctrl[CTL_SUM1] ? sum_sat : samp_a;
  wire [15:0] port2_w = ctrl[CTL_SUM2] ? sum_sat : samp_b;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      samp_valid <= 1'b0;
    end else if (fifo_ready) begin
      samp_valid <= 1'b1;
    end
  end

  dds_fifo #(
    .W     (32),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .sys_clk   (sys_clk),
    .rst       (rst),
    .in_valid  (samp_valid),
    .in_ready  (fifo_ready),
    .in_data   ({port2_w, port1_w}),
    .out_valid (out_valid),
    .out_ready (out_ready),
    .out_data  ({second_output_port, first_output_port})
  );
endmodule : dds_dual
`default_nettype wire

//--- hw/dds_pkg.sv
package dds_pkg;
  // Datapath widths
  localparam int WORD_W  = 52;
  localparam int FRAC_W  = 16;
  localparam int IDEAL_W = 68;
  localparam int SAMP_W  = 16;
  localparam int CTRL_W  = 10;
  localparam int FIFO_DEPTH_DEF = 16;
  // Synthesis clock rate in Hz
  localparam longint SYNTH_CLK_HZ = 64'd2500000000;
  // Register offsets
  localparam logic [7:0] OFS_CHAN_A    = 8'h00;
  localparam logic [7:0] OFS_CHAN_B    = 8'h20;
  localparam logic [7:0] OFS_CTRL      = 8'h40;
  localparam logic [7:0] OFS_CMD       = 8'h44;
  localparam logic [7:0] OFS_CPL_FREQ  = 8'h48;
  localparam logic [7:0] OFS_CPL_AMP   = 8'h4c;
  localparam logic [7:0] OFS_CPL_PHASE = 8'h50;
  localparam logic [7:0] OFS_STATUS    = 8'h54;
  // Offsets inside a channel block
  localparam logic [4:0] REG_FRAC    = 5'h00;
  localparam logic [4:0] REG_LO      = 5'h04;
  localparam logic [4:0] REG_HI      = 5'h08;
  localparam logic [4:0] REG_AMP     = 5'h0c;
  localparam logic [4:0] REG_PHASE   = 5'h10;
  localparam logic [4:0] REG_WAVE    = 5'h14;
  localparam logic [4:0] REG_WORD_LO = 5'h18;
  localparam logic [4:0] REG_WORD_HI = 5'h1c;
  // Control and command bits
  localparam int CTL_LOCK  = 0;
  localparam int CTL_TRACK = 1;
  localparam int CTL_CPF   = 2;
  localparam int CTL_CPA   = 3;
  localparam int CTL_CPP   = 4;
  localparam int CTL_RF    = 5;
  localparam int CTL_RA    = 6;
  localparam int CTL_RP    = 7;
  localparam int CTL_SUM1  = 8;
  localparam int CTL_SUM2  = 9;
  localparam int CMD_EQ    = 0;
  localparam int CMD_CP_AB = 1;
  localparam int CMD_CP_BA = 2;
  // Reset values, divide step count and saturation limits
  localparam logic [15:0] AMP_RST  = 16'h8000;
  localparam logic [15:0] CPL_RST  = 16'h0100;
  localparam logic [15:0] LFSR_RST = 16'hace1;
  localparam logic [6:0]  DIV_STEPS = 7'h44;
  localparam logic [15:0] SAT_POS  = 16'h7fff;
  localparam logic [15:0] SAT_NEG  = 16'h8000;
  // Waveform codes
  localparam logic [2:0] WAVE_SAW    = 3'h0;
  localparam logic [2:0] WAVE_SQUARE = 3'h1;
  localparam logic [2:0] WAVE_TRI    = 3'h2;
  localparam logic [2:0] WAVE_NOISE  = 3'h3;
  localparam logic [2:0] WAVE_DC     = 3'h4;
  // Tuning word calculator states
  typedef enum logic [1:0] {ST_IDLE, ST_DIV, ST_APPLY} dds_calc_t;
endpackage : dds_pkg

//--- hw/dds_fifo.sv
`timescale 1ns/1ns
`default_nettype none
module dds_fifo
  import dds_pkg::*;
#(
  parameter int W     = 32,
  parameter int DEPTH = FIFO_DEPTH_DEF
) (
  // Clock and reset
  input  wire logic         sys_clk,
  input  wire logic         rst,
  // Fill side
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  // Drain side
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [W-1:0] mem [DEPTH];
  logic [AW:0]  wp;
  logic [AW:0]  rp;

  wire full  = (wp[AW] != rp[AW]) && (wp[AW-1:0] == rp[AW-1:0]);
  wire empty = (wp == rp);
  wire push  = in_valid & ~full;
  wire pop   = ~empty & out_ready;

  assign in_ready  = ~full;
  assign out_valid = ~empty;
  assign out_data  = mem[rp[AW-1:0]];

  always_ff @(posedge sys_clk) begin
    if (push) begin
      mem[wp[AW-1:0]] <= in_data;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      wp <= '0;
      rp <= '0;
    end else begin
      wp <= wp + (AW+1)'(push);
      rp <= rp + (AW+1)'(pop);
    end
  end
endmodule : dds_fifo
`default_nettype wire

//--- hw/dds_chan.sv
`timescale 1ns/1ns
`default_nettype none
module dds_chan
  import dds_pkg::*;
#(
  parameter int AW = WORD_W
) (
  // Clock and reset
  input  wire logic          sys_clk,
  input  wire logic          rst,
  // Control
  input  wire logic          advance,
  input  wire logic          clear,
  input  wire logic [AW-1:0] word,
  input  wire logic [15:0]   phase_ofs,
  input  wire logic [15:0]   amp,
  input  wire logic [2:0]    wave,
  // Sample out
  output logic [SAMP_W-1:0]  sample
);
  logic [AW-1:0]      acc;
  logic [15:0]        lfsr;
  logic [15:0]        shape;
  logic signed [32:0] prod;

  wire [15:0] ph  = acc[AW-1 -: 16] + phase_ofs;
  wire [14:0] tri_v = ph[15] ? ~ph[14:0] : ph[14:0];

  always_comb begin
    case (wave)
      WAVE_SAW:    shape = ph ^ SAT_NEG;
      WAVE_SQUARE: shape = ph[15] ? SAT_NEG : SAT_POS;
      WAVE_TRI:    shape = {tri_v, 1'b0} ^ SAT_NEG;
      WAVE_NOISE:  shape = lfsr;
      WAVE_DC:     shape = SAT_POS;
      default:     shape = '0;
    endcase
  end

  assign prod = $signed(shape) * $signed({1'b0, amp});

  always_ff @(posedge sys_clk) begin
    if (rst || clear) begin
      acc <= '0;
    end else if (advance) begin
      acc <= acc + word;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      lfsr   <= LFSR_RST;
      sample <= '0;
    end else if (advance) begin
      lfsr   <= {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
      sample <= prod[31:16];
    end
  end
endmodule : dds_chan
`default_nettype wire

//--- verif/dds_dual_properties.sv
`timescale 1ns/1ns
`default_nettype none
module dds_dual_properties
  import dds_pkg::*;
(
  // Clock and reset
  input wire logic        sys_clk,
  input wire logic        rst,
  // Register bus
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic [31:0] hrdata,
  // Sample stream
  input wire logic        out_valid,
  input wire logic        out_ready,
  input wire logic [15:0] first_output_port,
  input wire logic [15:0] second_output_port
);
  logic rd;
  assign rd = hsel && htrans[1] && hready && !hwrite;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  chk_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus not ready or not okay");
  chk_reset_clear: assert property (disable iff (1'b0) rst |=> hrdata == 32'h0 && !out_valid)
    else $error("reset state wrong");
  chk_fifo_start: assert property ($fell(rst) |-> ##[0:4] out_valid)
    else $error("no samples after reset");
  chk_unmapped_zero: assert property (rd && haddr[7:0] > OFS_STATUS |=> hrdata == 32'h0)
    else $error("unmapped read not zero");
  chk_cmd_zero: assert property (rd && haddr[7:0] == OFS_CMD |=> hrdata == 32'h0)
    else $error("command read not zero");
  chk_ctrl_lock:
    assert property (rd && haddr[7:0] == OFS_CTRL |=> hrdata[CTL_LOCK] || !hrdata[CTL_TRACK])
    else $error("track without lock in control");
  chk_status_lock:
    assert property (rd && haddr[7:0] == OFS_STATUS |=> hrdata[0] || !hrdata[1])
    else $error("track without lock in status");
  chk_port_hold:
    assert property (out_valid && !out_ready |=> out_valid && $stable(first_output_port)
                     && $stable(second_output_port))
    else $error("stalled sample changed");
endmodule : dds_dual_properties
`default_nettype wire

//--- verif/dds_sink.sv
`timescale 1ns/1ns
`default_nettype none
module dds_sink (
  // Clock and stall request
  input  wire logic sys_clk,
  input  wire logic stall,
  // Stream
  input  wire logic out_valid,
  output logic      out_ready
);
  // Converter takes one pair per cycle unless stalled
  always @(posedge sys_clk) begin
    out_ready <= !stall;
  end
endmodule : dds_sink
`default_nettype wire

//--- verif/tb.sv
`timescale 1ns/1ns
`default_nettype none
module tb;
  import dds_pkg::*;
  logic        sys_clk, rst, hsel, hwrite, hreadyout, hresp, out_valid, out_ready, stall;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [15:0] first_output_port, second_output_port;
  logic [67:0] lk;
  int          num_errors, check_count, cycles;

  dds_dual i_dut (.sys_clk(sys_clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .out_valid(out_valid),
    .out_ready(out_ready), .first_output_port(first_output_port),
    .second_output_port(second_output_port));
  dds_sink i_sink (.sys_clk(sys_clk), .stall(stall), .out_valid(out_valid),
    .out_ready(out_ready));

  task automatic wrap_up();
    if (num_errors == 0 && check_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : wrap_up

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d,
                      output logic [31:0] r);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    haddr  <= {24'h0, a};
    hwrite <= w;
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask : xfer

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    xfer(a, 1'b1, d, r);
    @(posedge sys_clk);
  endtask : wr

  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] r;
    xfer(a, 1'b0, 32'h0, r);
    chk(r, e);
  endtask : rdc

  task automatic setf(input logic [7:0] b, input logic [67:0] v);
    logic [31:0] r;
    wr(b, {16'h0, v[15:0]});
    wr(b + 8'h04, v[47:16]);
    wr(b + 8'h08, {12'h0, v[67:48]});
    r = 32'h4;
    for (int n = 0; n < 60 && r[2]; n++) xfer(OFS_STATUS, 1'b0, 32'h0, r);
    chk({31'h0, r[2]}, 32'h0);
  endtask : setf

  task automatic wchk(input logic [7:0] b, input logic [51:0] e);
    rdc(b + 8'h18, e[31:0]);
    rdc(b + 8'h1c, {12'h0, e[51:32]});
  endtask : wchk

  task automatic grab(output logic [15:0] x, output logic [15:0] y);
    repeat (40) @(posedge sys_clk);
    @(negedge sys_clk);
    x = first_output_port;
    y = second_output_port;
    @(posedge sys_clk);
  endtask : grab

  task automatic align();
    logic [15:0] x, y;
    for (int n = 0; n < 8; n++) begin
      grab(x, y);
      chk({16'h0, x}, {16'h0, y});
    end
  endtask : align

  task automatic t_reset();
    rdc(OFS_CTRL, 32'h0);
    rdc(OFS_CHAN_A + 8'h0c, {16'h0, AMP_RST});
    rdc(OFS_CPL_FREQ, {16'h0, CPL_RST});
    rdc(8'h58, 32'h0);
    rdc(OFS_CMD, 32'h0);
  endtask : t_reset

  task automatic t_round();
    setf(OFS_CHAN_A, {52'h0_0123_4567_89ab, 16'h8000});
    setf(OFS_CHAN_B, {52'h0_0fed_cba9_8765, 16'h7fff});
    wchk(OFS_CHAN_A, 52'h0_0123_4567_89ac);
    setf(OFS_CHAN_A, {52'h0_0200_0000_0000, 16'h0});
    wchk(OFS_CHAN_B, 52'h0_0fed_cba9_8765);
  endtask : t_round

  task automatic t_lock();
    logic [51:0] w;
    lk = 68'd1801439850948 * 68'd65536 + 68'd12976;
    w  = lk[67:16] + {51'h0, lk[15]};
    wr(OFS_CTRL, 32'h1);
    setf(OFS_CHAN_A, lk);
    setf(OFS_CHAN_B, lk * 68'd10);
    wchk(OFS_CHAN_A, w);
    wchk(OFS_CHAN_B, w * 52'd10);
    rdc(OFS_STATUS, 32'h9);
    setf(OFS_CHAN_B, lk);
    align();
  endtask : t_lock

  task automatic t_equal();
    wr(OFS_CTRL, 32'h0);
    setf(OFS_CHAN_B, {52'h0_0100_0000_0000, 16'h0});
    repeat (20) @(posedge sys_clk);
    setf(OFS_CHAN_B, lk);
    wr(OFS_CMD, 32'h1);
    align();
  endtask : t_equal

  task automatic t_sum();
    logic [15:0] a0, b0, s, x, y;
    logic [16:0] t;
    wr(OFS_CHAN_A + 8'h14, {29'h0, WAVE_DC});
    wr(OFS_CHAN_B + 8'h14, {29'h0, WAVE_DC});
    for (int i = 0; i < 2; i++) begin
      wr(OFS_CHAN_A + 8'h0c, i ? 32'h2000 : 32'hffff);
      wr(OFS_CHAN_B + 8'h0c, i ? 32'h2000 : 32'hffff);
      wr(OFS_CTRL, 32'h0);
      grab(a0, b0);
      chk({16'h0, a0}, {16'h0, i ? 16'h0fff : 16'h7ffe});
      chk({16'h0, b0}, {16'h0, i ? 16'h0fff : 16'h7ffe});
      t = {a0[15], a0} + {b0[15], b0};
      s = (t[16] == t[15]) ? t[15:0] : (t[16] ? SAT_NEG : SAT_POS);
      for (int m = 1; m < 4; m++) begin
        wr(OFS_CTRL, m << 8);
        grab(x, y);
        chk({16'h0, x}, {16'h0, m[0] ? s : a0});
        chk({16'h0, y}, {16'h0, m[1] ? s : b0});
      end
    end
  endtask : t_sum

  task automatic t_track();
    wr(OFS_CTRL, 32'h2);
    rdc(OFS_CTRL, 32'h3);
    wr(OFS_CHAN_A + 8'h0c, 32'h1234);
    rdc(OFS_CHAN_B + 8'h0c, 32'h1234);
    wr(OFS_CHAN_B + 8'h0c, 32'h5555);
    rdc(OFS_CHAN_B + 8'h0c, 32'h1234);
    wr(OFS_CTRL, 32'h0);
  endtask : t_track

  task automatic t_couple();
    for (int i = 0; i < 4; i++) begin
      wr(i[1] ? OFS_CPL_PHASE : OFS_CPL_AMP, 32'h0200);
      wr(OFS_CTRL, i[1] ? (32'h10 | (i[0] << 7)) : (32'h8 | (i[0] << 6)));
      wr(OFS_CHAN_A + (i[1] ? 8'h10 : 8'h0c), 32'h0100);
      rdc(OFS_CHAN_B + (i[1] ? 8'h10 : 8'h0c), i[0] ? 32'h0200 : 32'h0300);
    end
    wr(OFS_CPL_FREQ, 32'h0200);
    wr(OFS_CTRL, 32'h24);
    setf(OFS_CHAN_A, {52'h0_0001_0000_0000, 16'h8000});
    wchk(OFS_CHAN_B, 52'h0_0002_0000_0001);
  endtask : t_couple

  task automatic t_copy();
    wr(OFS_CTRL, 32'h0);
    wr(OFS_CHAN_A + 8'h0c, 32'h4321);
    wr(OFS_CMD, 32'h2);
    rdc(OFS_CHAN_B + 8'h0c, 32'h4321);
    wr(OFS_CHAN_A + 8'h0c, 32'h1111);
    rdc(OFS_CHAN_B + 8'h0c, 32'h4321);
    wr(OFS_CHAN_B + 8'h0c, 32'h2222);
    wr(OFS_CMD, 32'h4);
    rdc(OFS_CHAN_A + 8'h0c, 32'h2222);
  endtask : t_copy

  task automatic t_stall();
    logic [15:0] x, y;
    wr(OFS_CHAN_A + 8'h14, {29'h0, WAVE_SAW});
    stall <= 1'b1;
    grab(x, y);
    repeat (30) @(posedge sys_clk);
    chk({16'h0, first_output_port}, {16'h0, x});
    stall <= 1'b0;
    repeat (40) @(posedge sys_clk);
  endtask : t_stall

  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end

  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      wrap_up();
    end
  end

  initial begin
    {rst, hsel, hwrite, stall, htrans, haddr, hwdata} = {1'b1, 69'h0};
    hsize = 3'h2;
    repeat (4) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    t_reset();
    t_round();
    t_lock();
    t_equal();
    t_sum();
    t_track();
    t_couple();
    t_copy();
    t_stall();
    wrap_up();
  end
endmodule : tb

bind dds_dual dds_dual_properties i_chk (.sys_clk(sys_clk), .rst(rst), .hsel(hsel),
  .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout),
  .hresp(hresp), .hrdata(hrdata), .out_valid(out_valid), .out_ready(out_ready),
  .first_output_port(first_output_port), .second_output_port(second_output_port));
`default_nettype wire
